// file: test/wlss_asserts.sv
module wlss_asserts (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// watched pins
	input wire logic refClockInput,
	input wire logic inputMissingOut,
	input wire logic inputMissingOeN,
	input wire logic autoClockPark,
	input wire logic extWrEn,
	input wire logic regsLocked
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] quietCnt;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	// saturating count of edges with no change on the raw reference
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			quietCnt <= 8'h00;
		else if ($changed(refClockInput))
			quietCnt <= 8'h00;
		else if (quietCnt != 8'hFF)
			quietCnt <= quietCnt + 8'h01;
	end
	////////////////////////////////////////
	a_park_tracks_pin: assert property (autoClockPark == !inputMissingOeN)
		else $error("park and missing pin disagree");
	a_pin_never_high: assert property (!inputMissingOut)
		else $error("missing pin driven high");
	a_loss_parks: assert property (quietCnt >= 8'h32 |-> autoClockPark)
		else $error("quiet reference not parked");
	a_loss_not_early: assert property ($fell(inputMissingOeN) |-> quietCnt >= 8'h29)
		else $error("loss flagged too early");
	a_edge_frees_pin: assert property ($changed(refClockInput) && $past(arst_n) |-> ##[1:7] !autoClockPark)
		else $error("running reference still parked");
	a_locked_no_write: assert property (regsLocked |-> !extWrEn)
		else $error("write passed while locked");
	a_write_one_pulse: assert property (extWrEn |=> !extWrEn)
		else $error("write strobe too long");
	a_lock_stays_set: assert property ($rose(regsLocked) |=> regsLocked [*8])
		else $error("lock dropped by itself");
	a_reset_parked: assert property ($rose(arst_n) |-> autoClockPark && !inputMissingOeN)
		else $error("not parked after reset");
endmodule

bind wlss_top wlss_asserts u_chk (.clock(clock), .arst_n(arst_n), .refClockInput(refClockInput),
	.inputMissingOut(inputMissingOut), .inputMissingOeN(inputMissingOeN),
	.autoClockPark(autoClockPark), .extWrEn(extWrEn), .regsLocked(regsLocked));

// file: test/wlss_host_src.sv
`include "wlss_cfg.svh"

module wlss_host_src (
	// clock
	input  wire logic clock,
	// management pins
	output logic      smbClkIn,
	output logic      smbDataIn,
	input  wire logic smbDataOeN,
	// reference source
	input  wire logic refRun,
	output logic      refClockInput
);
	timeunit 1ns;
	timeprecision 100ps;
	import wlss_pkg::*;
	logic sclDrv = 1'b1;
	logic sdaDrv = 1'b1;
	// pulled-up data wire, low when either side pulls
	assign smbClkIn  = sclDrv;
	assign smbDataIn = sdaDrv & smbDataOeN;
	initial refClockInput = 1'b0;
	// the reference stands still while stopped
	always begin
		tick(3);
		if (refRun)
			refClockInput = ~refClockInput;
	end
	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// data moves only mid-low so no false start or stop is seen
	task automatic bitx(input logic b, output logic r);
		sclDrv = 1'b0;
		tick(3);
		sdaDrv = b;
		tick(3);
		sclDrv = 1'b1;
		tick(5);
		r = smbDataIn;
		tick(1);
	endtask
	// start when fin is 0, stop when fin is 1
	task automatic frame(input logic fin);
		sclDrv = 1'b0;
		tick(3);
		sdaDrv = ~fin;
		tick(3);
		sclDrv = 1'b1;
		tick(6);
		sdaDrv = fin;
		tick(6);
	endtask
	task automatic xfer(input wlss_byte_t v, output wlss_byte_t r);
		logic a;
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r[i]);
		bitx(1'b1, a);
	endtask
	task automatic wr(input wlss_byte_t a, input wlss_byte_t d);
		wlss_byte_t r;
		frame(1'b0);
		xfer({`WLSS_SMB_ADDR_DEFAULT, 1'b0}, r);
		xfer(a, r);
		xfer(d, r);
		frame(1'b1);
	endtask
	task automatic rd(input wlss_byte_t a, output wlss_byte_t d);
		wlss_byte_t r;
		frame(1'b0);
		xfer({`WLSS_SMB_ADDR_DEFAULT, 1'b0}, r);
		xfer(a, r);
		frame(1'b0);
		xfer({`WLSS_SMB_ADDR_DEFAULT, 1'b1}, r);
		xfer(8'hFF, d);
		frame(1'b1);
	endtask
endmodule

// file: test/wlss_top_bench.sv
module wlss_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import wlss_pkg::*;
	logic       clock;
	logic       arst_n;
	logic       sbEn;
	logic       refRun;
	wlss_byte_t extRd;
	wlss_byte_t rv, ea, ed, gotA, gotD, extAddr, extWrData;
	logic       smbClk, smbDat, smbOeN, refClk, missOeN, park, extWrEn, locked, sdaOut, missOut;
	int         mismatches = 0;
	int         n_checks   = 0;
	int         nExt       = 0;
	int         cyc        = 0;

	wlss_top dut (.clock(clock), .arst_n(arst_n), .smbClkIn(smbClk), .smbDataIn(smbDat),
		.smbDataOut(sdaOut), .smbDataOeN(smbOeN), .refClockInput(refClk), .sidebandIfaceEnable(sbEn),
		.inputMissingOut(missOut), .inputMissingOeN(missOeN), .autoClockPark(park), .extWrEn(extWrEn),
		.extAddr(extAddr), .extWrData(extWrData), .extRdData(extRd), .regsLocked(locked));
	wlss_host_src u_host (.clock(clock), .smbClkIn(smbClk), .smbDataIn(smbDat),
		.smbDataOeN(smbOeN), .refRun(refRun), .refClockInput(refClk));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// the ceiling is some four times the planned run
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (extWrEn === 1'b1) begin
			nExt <= nExt + 1;
			gotA <= extAddr;
			gotD <= extWrData;
		end
		if (cyc == 60000) begin
			mismatches = mismatches + 1;
			give_verdict();
		end
	end
	////////////////////////////////////////
	function automatic wlss_byte_t live(input logic p);
		return {extRd[7:1], p};
	endfunction
	function automatic wlss_byte_t st27(input logic lk, input logic ev);
		return {6'h00, ev, lk};
	endfunction
	task automatic chk(input string n, input wlss_byte_t s, input wlss_byte_t e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input wlss_byte_t a, input wlss_byte_t e);
		u_host.rd(a, rv);
		chk("register", rv, e);
	endtask
	task automatic extw(input logic ok);
		int n0;
		n0 = nExt;
		extRd = 8'($urandom);
		ea = 8'($urandom_range(8'h25, 8'h13));
		ed = 8'($urandom);
		u_host.wr(ea, ed);
		chk("ext count", 8'(nExt - n0), 8'(ok));
		if (ok)
			chk("ext addr", gotA, ea);
		if (ok)
			chk("ext data", gotD, ed);
	endtask
	task automatic drop();
		refRun = 1'b0;
		u_host.tick(60);
		refRun = 1'b1;
		u_host.tick(20);
	endtask
	task automatic rst();
		arst_n = 1'b0;
		u_host.tick(4);
		arst_n = 1'b1;
		u_host.tick(4);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		sbEn = 1'b1;
		refRun = 1'b0;
		void'($urandom(32'haa337acb));
		extRd = 8'($urandom);
		rst();
		rchk(8'h27, st27(0, 0));
		rchk(8'h26, 8'h00);
		chk("park", 8'(park), 8'h01);
		rchk(8'h12, live(0));
		chk("drive levels", 8'({sdaOut, missOut}), 8'h00);
		$display("test powerup done");
		refRun = 1'b1;
		u_host.tick(20);
		chk("pin", 8'(missOeN), 8'h01);
		rchk(8'h12, live(1));
		rchk(8'h27, st27(0, 0));
		refRun = 1'b0;
		u_host.tick(60);
		chk("park", 8'(park), 8'h01);
		chk("pin", 8'(missOeN), 8'h00);
		rchk(8'h12, live(0));
		refRun = 1'b1;
		u_host.tick(20);
		rchk(8'h27, st27(0, 1));
		u_host.wr(8'h27, 8'h00);
		rchk(8'h27, st27(0, 1));
		u_host.wr(8'h27, 8'h02);
		rchk(8'h27, st27(0, 0));
		sbEn = 1'b0;
		drop();
		rchk(8'h27, 8'h00);
		u_host.wr(8'h27, 8'h02);
		sbEn = 1'b1;
		u_host.tick(5);
		rchk(8'h27, st27(0, 1));
		u_host.wr(8'h27, 8'h02);
		$display("test loss done");
		repeat (3) extw(1'b1);
		rchk(8'h12, live(1));
		chk("drive levels", 8'({sdaOut, missOut}), 8'h00);
		u_host.wr(8'h27, 8'h01);
		rchk(8'h27, st27(1, 0));
		chk("locked", 8'(locked), 8'h01);
		extw(1'b0);
		u_host.wr(8'h26, 8'h01);
		rchk(8'h26, 8'h00);
		u_host.wr(8'h27, 8'h01);
		rchk(8'h27, st27(0, 0));
		extw(1'b1);
		$display("test clearable done");
		u_host.wr(8'h26, 8'h01);
		rchk(8'h26, 8'h01);
		u_host.wr(8'h26, 8'h00);
		rchk(8'h26, 8'h01);
		extw(1'b0);
		drop();
		rchk(8'h27, st27(0, 1));
		u_host.wr(8'h27, 8'h02);
		rchk(8'h27, st27(0, 0));
		chk("locked", 8'(locked), 8'h01);
		rst();
		rchk(8'h26, 8'h00);
		chk("locked", 8'(locked), 8'h00);
		$display("test permanent done");
		give_verdict();
	end
endmodule

// file: verilog/wlss_cfg.svh
`ifndef WLSS_CFG_SVH
`define WLSS_CFG_SVH

// register indices (byte addresses on the management bus)
`define WLSS_REG_LIVE_RB      8'h12
`define WLSS_REG_PERM_LOCK    8'h26
`define WLSS_REG_CLR_LOCK_EVT 8'h27

// field positions
`define WLSS_BIT_PERM_LOCK    0
`define WLSS_BIT_CLR_LOCK     0
`define WLSS_BIT_MISSING_EVT  1
`define WLSS_BIT_LIVE_RB      0

// reset values
`define WLSS_RST_PERM_LOCK    1'b0
`define WLSS_RST_CLR_LOCK     1'b0
`define WLSS_RST_MISSING_EVT  1'b0

// timing: the reference counts as missing after this long without a transition
`define WLSS_CLK_PERIOD_NS    25
`define WLSS_LOSS_TIME_NS     1000
`define WLSS_LOSS_CYCLES      ((`WLSS_LOSS_TIME_NS + `WLSS_CLK_PERIOD_NS - 1) / `WLSS_CLK_PERIOD_NS)
`define WLSS_LOSS_CNT_W       8

// serial framing
`define WLSS_BITS_PER_BYTE    4'h8
`define WLSS_SMB_ADDR_DEFAULT 7'h10

`endif

// file: verilog/wlss_edge_watch.sv
`include "wlss_cfg.svh"

module wlss_edge_watch (
	// clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// synchronised reference sample
	input  wire logic refSample,
	// detector decision
	output logic      clockPresent
);
	import wlss_pkg::*;

	localparam logic [`WLSS_LOSS_CNT_W-1:0] LOSS_CNT = `WLSS_LOSS_CNT_W'(`WLSS_LOSS_CYCLES);

	logic                        sampleD_reg;
	logic [`WLSS_LOSS_CNT_W-1:0] idleCnt_reg;
	logic [`WLSS_LOSS_CNT_W-1:0] idleCnt_next;
	logic                        present_reg;
	logic                        present_next;
	logic                        transition;
	logic                        timedOut;

	////////////////////////////////////////////////////////////////////////////////
	// any level change proves the reference is toggling; a reference faster than
	// half the sampling rate aliases, so only its presence is judged, not its rate
	assign transition   = refSample ^ sampleD_reg;
	assign timedOut     = (idleCnt_reg == LOSS_CNT);
	assign idleCnt_next = transition ? '0 : (timedOut ? idleCnt_reg : idleCnt_reg + 1'b1);
	assign present_next = transition ? 1'b1 : (timedOut ? 1'b0 : present_reg);  // [R08]

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sampleD_reg <= 1'b0;
			idleCnt_reg <= '0;
			present_reg <= 1'b0;
		end else begin
			sampleD_reg <= refSample;
			idleCnt_reg <= idleCnt_next;
			present_reg <= present_next;
		end
	end

	assign clockPresent = present_reg;

endmodule

// file: verilog/wlss_pkg.sv
package wlss_pkg;

	typedef logic [7:0] wlss_byte_t;

	typedef enum logic [4:0] {
		WLSS_ST_IDLE  = 5'h01,
		WLSS_ST_ADDR  = 5'h02,
		WLSS_ST_CMD   = 5'h04,
		WLSS_ST_WRITE = 5'h08,
		WLSS_ST_READ  = 5'h10
	} wlss_state_t;

endpackage

// file: verilog/wlss_top.sv
// Overview of operation
// R01: Either write lock set makes the device ignore writes to control registers.
// R02: Permanent lock at bit 0 of register 38; only reset clears it.
// R03: Clearable lock at bit 0 of register 39 clears when one is written.
// R04: Both lock bits are zero after power-up, so writes start allowed.
// R05: Missing-input event flag, bit 1 of register 39, sticky, zero after reset.
// R06: Writing one clears the event flag; writing zero leaves it alone.
// R07: Register 39 is honoured only while the sideband interface enable is high.
// R08: A detector continuously decides whether the reference clock is present.
// R09: Open-drain active-low missing pin pulls low while clock absent.
// R10: The detector's loss event sets the event flag.
// R11: After a loss event the clock path is parked low/low.
// R12: Read-only live bit: zero while loss detected, one while clock present.
// R13: One written to clearable lock sets it when clear, clears it when set.
// R14: Register 39 accepts writes even while a write lock is active.
`include "wlss_cfg.svh"

module wlss_top #(
	parameter logic [6:0] SMB_ADDR = `WLSS_SMB_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              arst_n,
	// management serial pins
	input  wire logic              smbClkIn,
	input  wire logic              smbDataIn,
	output logic                   smbDataOut,
	output logic                   smbDataOeN,
	// monitored reference and sideband enable
	input  wire logic              refClockInput,
	input  wire logic              sidebandIfaceEnable,
	// missing-input open-drain pin and parking
	output logic                   inputMissingOut,
	output logic                   inputMissingOeN,
	output logic                   autoClockPark,
	// port to the remaining control registers
	output logic                   extWrEn,
	output wlss_pkg::wlss_byte_t   extAddr,
	output wlss_pkg::wlss_byte_t   extWrData,
	input  wire wlss_pkg::wlss_byte_t extRdData,
	output logic                   regsLocked
);
	import wlss_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one is read only by stage two
	logic [3:0] syncA_reg;
	logic [3:0] syncB_reg;
	logic       sclD_reg;
	logic       sdaD_reg;
	logic       refS;
	logic       sbEnS;
	logic       sclS;
	logic       sdaS;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			// reference stage resets low like the detector's last sample: no false edge at release
			syncA_reg <= 4'h7;
			syncB_reg <= 4'h7;
		end else begin
			syncA_reg <= {refClockInput, sidebandIfaceEnable, smbClkIn, smbDataIn};
			syncB_reg <= syncA_reg;
		end
	end

	assign refS  = syncB_reg[3];
	assign sbEnS = syncB_reg[2];
	assign sclS  = syncB_reg[1];
	assign sdaS  = syncB_reg[0];

	////////////////////////////////////////////////////////////////////////////////
	// missing-input detector and its event edge
	logic present;
	logic presentD_reg;
	logic lossEvent;

	wlss_edge_watch uWatch (
		.clock        (clock),
		.arst_n       (arst_n),
		.refSample    (refS),
		.clockPresent (present)
	);

	assign lossEvent = presentD_reg & ~present;

	////////////////////////////////////////////////////////////////////////////////
	// serial slave: byte write (cmd, data...) and byte read with repeated start
	wlss_state_t state_reg;
	wlss_state_t state_next;
	logic [3:0]  bitCnt_reg;
	logic [3:0]  bitCnt_next;
	wlss_byte_t  shiftIn_reg;
	wlss_byte_t  shiftIn_next;
	wlss_byte_t  txByte_reg;
	wlss_byte_t  txByte_next;
	wlss_byte_t  ptr_reg;
	wlss_byte_t  ptr_next;
	logic        pull_reg;
	logic        pull_next;
	logic        wrStrobe_reg;
	logic        wrStrobe_next;
	wlss_byte_t  wrAddr_reg;
	wlss_byte_t  wrAddr_next;
	wlss_byte_t  wrData_reg;
	wlss_byte_t  wrData_next;
	wlss_byte_t  readData;
	logic        sclRise;
	logic        sclFall;
	logic        startCond;
	logic        stopCond;
	logic        byteDone;
	logic        addrHit;

	assign sclRise   = sclS & ~sclD_reg;
	assign sclFall   = ~sclS & sclD_reg;
	assign startCond = sclS & sclD_reg & sdaD_reg & ~sdaS;
	assign stopCond  = sclS & sclD_reg & ~sdaD_reg & sdaS;
	assign byteDone  = (bitCnt_reg == `WLSS_BITS_PER_BYTE);
	assign addrHit   = (shiftIn_reg[7:1] == SMB_ADDR);

	always_comb begin
		state_next    = state_reg;
		bitCnt_next   = bitCnt_reg;
		shiftIn_next  = shiftIn_reg;
		txByte_next   = txByte_reg;
		ptr_next      = ptr_reg;
		pull_next     = pull_reg;
		wrStrobe_next = 1'b0;
		wrAddr_next   = wrAddr_reg;
		wrData_next   = wrData_reg;
		if (startCond) begin
			state_next  = WLSS_ST_ADDR;
			bitCnt_next = 4'h0;
			pull_next   = 1'b0;
		end else if (stopCond) begin
			state_next  = WLSS_ST_IDLE;
			bitCnt_next = 4'h0;
			pull_next   = 1'b0;
		end else if (state_reg != WLSS_ST_IDLE) begin
			if (sclRise) begin
				if (byteDone) begin
					// ninth clock: in a read the master's ack decides whether to go on
					bitCnt_next = 4'h0;
					if (state_reg == WLSS_ST_READ) begin
						if (sdaS) begin
							state_next = WLSS_ST_IDLE;
						end else begin
							txByte_next = readData;
							ptr_next    = ptr_reg + 8'h01;
						end
					end
				end else begin
					shiftIn_next = {shiftIn_reg[6:0], sdaS};
					bitCnt_next  = bitCnt_reg + 4'h1;
				end
			end
			if (sclFall) begin
				if (byteDone) begin
					case (state_reg)
						WLSS_ST_ADDR: begin
							if (!addrHit) begin
								state_next = WLSS_ST_IDLE;
							end else if (shiftIn_reg[0]) begin
								// first byte loads on the ninth clock, where our own ack reads as a master ack
								pull_next  = 1'b1;
								state_next = WLSS_ST_READ;
							end else begin
								pull_next  = 1'b1;
								state_next = WLSS_ST_CMD;
							end
						end
						WLSS_ST_CMD: begin
							pull_next  = 1'b1;
							ptr_next   = shiftIn_reg;
							state_next = WLSS_ST_WRITE;
						end
						WLSS_ST_WRITE: begin
							pull_next     = 1'b1;
							wrStrobe_next = 1'b1;
							wrAddr_next   = ptr_reg;
							wrData_next   = shiftIn_reg;
							ptr_next      = ptr_reg + 8'h01;
						end
						WLSS_ST_READ: begin
							pull_next = 1'b0;
						end
						default: begin
							state_next = WLSS_ST_IDLE;
							pull_next  = 1'b0;
						end
					endcase
				end else if (state_reg == WLSS_ST_READ) begin
					pull_next = ~txByte_reg[3'h7 - bitCnt_reg[2:0]];
				end else begin
					pull_next = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg    <= WLSS_ST_IDLE;
			bitCnt_reg   <= 4'h0;
			shiftIn_reg  <= 8'h00;
			txByte_reg   <= 8'h00;
			ptr_reg      <= 8'h00;
			pull_reg     <= 1'b0;
			wrStrobe_reg <= 1'b0;
			wrAddr_reg   <= 8'h00;
			wrData_reg   <= 8'h00;
			sclD_reg     <= 1'b1;
			sdaD_reg     <= 1'b1;
		end else begin
			state_reg    <= state_next;
			bitCnt_reg   <= bitCnt_next;
			shiftIn_reg  <= shiftIn_next;
			txByte_reg   <= txByte_next;
			ptr_reg      <= ptr_next;
			pull_reg     <= pull_next;
			wrStrobe_reg <= wrStrobe_next;
			wrAddr_reg   <= wrAddr_next;
			wrData_reg   <= wrData_next;
			sclD_reg     <= sclS;
			sdaD_reg     <= sdaS;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// lock and event register bank
	logic permLock_reg;
	logic permLock_next;
	logic clrLock_reg;
	logic clrLock_next;
	logic missEvt_reg;
	logic missEvt_next;
	logic lockActive;
	logic hitPerm;
	logic hitClr;
	logic wrPerm;
	logic wrClr;
	logic wrExt;

	assign lockActive    = permLock_reg | clrLock_reg;
	assign hitPerm       = (wrAddr_reg == `WLSS_REG_PERM_LOCK);
	assign hitClr        = (wrAddr_reg == `WLSS_REG_CLR_LOCK_EVT);
	assign wrPerm        = wrStrobe_reg & hitPerm & ~lockActive;  // [R01]
	assign wrClr         = wrStrobe_reg & hitClr & sbEnS;  // [R14] [R07]
	assign wrExt         = wrStrobe_reg & ~hitPerm & ~hitClr & ~lockActive;  // [R01]
	// sticky: writes can only raise it
	assign permLock_next = permLock_reg | (wrPerm & wrData_reg[`WLSS_BIT_PERM_LOCK]);  // [R02]
	// one write both arms and disarms, so a one toggles it
	assign clrLock_next  = clrLock_reg ^ (wrClr & wrData_reg[`WLSS_BIT_CLR_LOCK]);  // [R03] [R13]
	// a loss in the clearing cycle wins over the clear
	assign missEvt_next  = lossEvent
	                     | (missEvt_reg & ~(wrClr & wrData_reg[`WLSS_BIT_MISSING_EVT]));  // [R05] [R06] [R10]

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			permLock_reg <= `WLSS_RST_PERM_LOCK;  // [R04]
			clrLock_reg  <= `WLSS_RST_CLR_LOCK;  // [R04]
			missEvt_reg  <= `WLSS_RST_MISSING_EVT;  // [R05]
		end else begin
			permLock_reg <= permLock_next;
			clrLock_reg  <= clrLock_next;
			missEvt_reg  <= missEvt_next;
		end
	end

	// read mux
	wlss_byte_t rdPerm;
	wlss_byte_t rdClr;
	wlss_byte_t rdLive;

	assign rdPerm   = {7'h00, permLock_reg};
	assign rdClr    = sbEnS ? {6'h00, missEvt_reg, clrLock_reg} : 8'h00;  // [R07]
	assign rdLive   = {extRdData[7:1], present};  // [R12]
	assign readData = (ptr_reg == `WLSS_REG_PERM_LOCK)    ? rdPerm :
	                  (ptr_reg == `WLSS_REG_CLR_LOCK_EVT) ? rdClr  :
	                  (ptr_reg == `WLSS_REG_LIVE_RB)      ? rdLive : extRdData;

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs
	logic       missOeN_reg;
	logic       park_reg;
	logic       extWrEn_reg;
	wlss_byte_t extAddr_reg;
	wlss_byte_t extWrData_reg;
	logic       locked_reg;
	logic       zero_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			presentD_reg  <= 1'b0;
			missOeN_reg   <= 1'b0;
			park_reg      <= 1'b1;
			extWrEn_reg   <= 1'b0;
			extAddr_reg   <= 8'h00;
			extWrData_reg <= 8'h00;
			locked_reg    <= 1'b0;
			zero_reg      <= 1'b0;
		end else begin
			presentD_reg  <= present;
			missOeN_reg   <= present;  // [R09]
			park_reg      <= ~present;  // [R11]
			extWrEn_reg   <= wrExt;
			extAddr_reg   <= wrAddr_reg;
			extWrData_reg <= wrData_reg;
			locked_reg    <= lockActive;
			zero_reg      <= 1'b0;
		end
	end

	assign smbDataOut      = zero_reg;
	assign smbDataOeN      = ~pull_reg;
	assign inputMissingOut = zero_reg;
	assign inputMissingOeN = missOeN_reg;
	assign autoClockPark   = park_reg;
	assign extWrEn         = extWrEn_reg;
	assign extAddr         = extAddr_reg;
	assign extWrData       = extWrData_reg;
	assign regsLocked      = locked_reg;

endmodule
